// >>> hdl/tmr_top.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module tmr_top #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [1:0] event_input_pin_i,
  input wire logic neighbour_timer_irq_i,
  output logic [1:0] timer_output_pin_o,
  output logic [1:0] match_irq_o
);
  import tmr_pkg::*;

  // ----------------------------------------------------------------
  // apb slave: one wait state, answer from flip-flops
  // ----------------------------------------------------------------
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [3:0] word_idx;
  logic access;
  logic hit_cnt0, hit_cnt1, hit_mode0, hit_mode1;
  logic hit_cmp0, hit_cmp1, hit_sel0, hit_sel1;
  logic mapped;
  logic wr_fire;
  logic [7:0] rd_byte;

  logic [7:0] mode_reg [2];
  logic [7:0] cmp_reg [2];
  logic [2:0] sel_reg [2];
  logic [7:0] cnt_reg [2];
  logic [1:0] outff_reg;
  logic [1:0] pwm_lvl_reg;
  logic [1:0] pin_reg;
  logic [1:0] irq_reg;
  logic [7:0] presc_reg;
  logic [1:0] ev_prev_reg;
  logic nb_prev_reg;

  assign word_idx = paddr_i[5:2];
  assign access = psel_i && penable_i;
  assign hit_cnt0 = word_idx == TMR_CH0_COUNT_IDX[TMR_IDX_BITS-1:0];
  assign hit_cnt1 = word_idx == TMR_CH1_COUNT_IDX[TMR_IDX_BITS-1:0];
  assign hit_mode0 = word_idx == TMR_CH0_MODE_IDX[TMR_IDX_BITS-1:0];
  assign hit_mode1 = word_idx == TMR_CH1_MODE_IDX[TMR_IDX_BITS-1:0];
  assign hit_cmp0 = word_idx == TMR_CH0_CMP_IDX[TMR_IDX_BITS-1:0];
  assign hit_cmp1 = word_idx == TMR_CH1_CMP_IDX[TMR_IDX_BITS-1:0];
  assign hit_sel0 = word_idx == TMR_CH0_CLKSEL_IDX[TMR_IDX_BITS-1:0];
  assign hit_sel1 = word_idx == TMR_CH1_CLKSEL_IDX[TMR_IDX_BITS-1:0];
  assign mapped = (paddr_i[ADDR_W-1:6] == '0) && (hit_cnt0 || hit_cnt1 || hit_mode0 ||
                  hit_mode1 || hit_cmp0 || hit_cmp1 || hit_sel0 || hit_sel1);
  // writes land only on the completing edge of the access phase
  assign wr_fire = access && pready_reg && pwrite_i && mapped;

  // read mux; counters read live, the upper byte of a cascade included
  // byte wide access
  assign rd_byte = hit_cnt0 ? cnt_reg[0] :
                   hit_cnt1 ? cnt_reg[1] :
                   hit_mode0 ? mode_reg[0] :
                   hit_mode1 ? mode_reg[1] :
                   hit_cmp0 ? cmp_reg[0] :
                   hit_cmp1 ? cmp_reg[1] :
                   hit_sel0 ? {5'h00, sel_reg[0]} :
                   hit_sel1 ? {5'h00, sel_reg[1]} : 8'h00;

  // answer handshake; pready drops straight after each completion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= access && !pready_reg;
      pslverr_reg <= access && !pready_reg && !mapped;
      prdata_reg <= (access && !pready_reg && !pwrite_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;

  // ----------------------------------------------------------------
  // shared prescaler and input edge detection
  // ----------------------------------------------------------------
  // one free-running prescaler serves both channels, so a start may
  // lose up to one divided tick; edge registers idle low like the pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_reg <= 8'h00;
      ev_prev_reg <= 2'b00;
      nb_prev_reg <= 1'b0;
    end else begin
      presc_reg <= presc_reg + 8'h01;
      ev_prev_reg <= event_input_pin_i;
      nb_prev_reg <= neighbour_timer_irq_i;
    end
  end

  logic casc;
  logic [15:0] cnt16;
  logic [15:0] cmp16;
  logic match16;
  logic [1:0] tick;
  logic [1:0] step;
  logic [1:0] run_eff;
  logic [1:0] clr_match;
  logic [1:0] irq_ev;

  assign casc = mode_reg[1][TMR_MODE_CASC_BIT];
  assign cnt16 = {cnt_reg[1], cnt_reg[0]};
  assign cmp16 = {cmp_reg[1], cmp_reg[0]};
  assign match16 = cnt16 == cmp16;

  // ----------------------------------------------------------------
  // per-channel counter, compare and output logic
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic wr_mode, wr_cmp, wr_sel;
    logic pwm, tog_pol, oe, match8, inc, toggle, pin_next;
    logic [7:0] cnt_plus;
    logic [7:0] mode_wdata;

    assign wr_mode = wr_fire && (i == 0 ? hit_mode0 : hit_mode1);
    assign wr_cmp = wr_fire && (i == 0 ? hit_cmp0 : hit_cmp1);
    assign wr_sel = wr_fire && (i == 0 ? hit_sel0 : hit_sel1);
    // the lower channel has no cascade bit; it reads as zero
    assign mode_wdata = (i == 0) ? (pwdata_i[7:0] & ~(8'h01 << TMR_MODE_CASC_BIT)) : pwdata_i[7:0];
    assign pwm = mode_reg[i][TMR_MODE_PWM_BIT] && !casc;
    assign tog_pol = mode_reg[i][TMR_MODE_TOG_BIT];
    assign oe = mode_reg[i][TMR_MODE_OE_BIT];
    assign cnt_plus = cnt_reg[i] + 8'h01;
    assign match8 = cnt_reg[i] == cmp_reg[i];

    always_comb begin
      case (tmr_clksel_t'(sel_reg[i]))
        TMR_SEL_EV_FALL: tick[i] = ev_prev_reg[i] && !event_input_pin_i[i];
        TMR_SEL_EV_RISE: tick[i] = !ev_prev_reg[i] && event_input_pin_i[i];
        TMR_SEL_DIV1: tick[i] = 1'b1;
        TMR_SEL_DIV2: tick[i] = &presc_reg[TMR_TAP_DIV2-1:0];
        TMR_SEL_DIV4: tick[i] = &presc_reg[TMR_TAP_DIV4-1:0];
        TMR_SEL_DIV64: tick[i] = &presc_reg[TMR_TAP_DIV64-1:0];
        TMR_SEL_DIV256: tick[i] = &presc_reg[TMR_TAP_DIV256-1:0];
        default: tick[i] = neighbour_timer_irq_i && !nb_prev_reg;
      endcase
    end

    // lower run bit governs the cascade
    assign run_eff[i] = (i == 1 && casc) ? mode_reg[0][TMR_MODE_RUN_BIT] : mode_reg[i][TMR_MODE_RUN_BIT];
    // upper half steps on lower wrap
    assign step[i] = run_eff[i] && ((i == 1 && casc) ? tick[0] : tick[i]);
    assign inc = (i == 1 && casc) ? (cnt_reg[0] == TMR_COUNT_MAX) : 1'b1;
    assign clr_match[i] = casc ? match16 : (!pwm && match8);
    assign irq_ev[i] = step[i] && (casc ? (i == 0 && match16) : match8);
    assign toggle = step[i] && clr_match[i] && tog_pol && !pwm && (i == 0 || !casc);

    always_ff @(posedge clk_i) begin
      if (rst_i || !run_eff[i]) begin
        cnt_reg[i] <= TMR_COUNT_RST;
      end else if (step[i]) begin
        cnt_reg[i] <= clr_match[i] ? TMR_COUNT_RST : (inc ? cnt_plus : cnt_reg[i]);
      end
    end

    // software registers
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mode_reg[i] <= TMR_MODE_RST;
        cmp_reg[i] <= TMR_CMP_RST;
        sel_reg[i] <= TMR_CLKSEL_RST;
      end else begin
        if (wr_mode) mode_reg[i] <= mode_wdata;
        if (wr_cmp) cmp_reg[i] <= pwdata_i[7:0];
        if (wr_sel) sel_reg[i] <= pwdata_i[2:0];
      end
    end

    // software set or clear wins over toggle
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        outff_reg[i] <= 1'b0;
      end else if (wr_mode && pwdata_i[TMR_MODE_SET_BIT] && !pwdata_i[TMR_MODE_CLR_BIT]) begin
        outff_reg[i] <= 1'b1;
      end else if (wr_mode && pwdata_i[TMR_MODE_CLR_BIT] && !pwdata_i[TMR_MODE_SET_BIT]) begin
        outff_reg[i] <= 1'b0;
      end else if (toggle) begin
        outff_reg[i] <= !outff_reg[i];
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i || !run_eff[i] || !pwm) begin
        pwm_lvl_reg[i] <= 1'b0;
      end else if (step[i]) begin
        if (cnt_plus == cmp_reg[i]) pwm_lvl_reg[i] <= 1'b0;
        else if (cnt_reg[i] == TMR_COUNT_MAX) pwm_lvl_reg[i] <= 1'b1;
      end
    end

    // disabled output holds the pin low
    assign pin_next = oe && (pwm ? (pwm_lvl_reg[i] ^ tog_pol) : outff_reg[i]);

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pin_reg[i] <= 1'b0;
        irq_reg[i] <= 1'b0;
      end else begin
        pin_reg[i] <= pin_next;
        irq_reg[i] <= irq_ev[i];
      end
    end
  end

  assign timer_output_pin_o = pin_reg;
  assign match_irq_o = irq_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  cnt_step_a: assert property (cnt_reg[0] != $past(cnt_reg[0]) |->
    cnt_reg[0] == $past(cnt_reg[0]) + 8'h01 || cnt_reg[0] == 8'h00)
    else $error("lower count jumped");
  stop_clear_a: assert property (!mode_reg[1][TMR_MODE_RUN_BIT] && !casc |=> cnt_reg[1] == 8'h00)
    else $error("stopped counter not zero");
  casc_clear_a: assert property (casc && !mode_reg[0][TMR_MODE_RUN_BIT] |=> cnt16 == 16'h0000)
    else $error("cascade not cleared by lower stop");
  match_irq_a: assert property (step[0] && !casc && !g_ch[0].pwm && g_ch[0].match8
    |=> match_irq_o[0] && cnt_reg[0] == 8'h00)
    else $error("match did not raise interrupt");
  cmp_top_a: assert property (step[1] && !casc && !g_ch[1].pwm && cnt_reg[1] == 8'hFF &&
    cmp_reg[1] == 8'hFF |=> cnt_reg[1] == 8'h00 && match_irq_o[1])
    else $error("top compare missed");
  casc_irq_a: assert property (casc |=> !match_irq_o[1])
    else $error("upper interrupt in cascade");
  casc_wrap_a: assert property (casc && step[0] && cnt_reg[0] == 8'hFF && !match16
    |=> cnt_reg[1] == $past(cnt_reg[1]) + 8'h01)
    else $error("upper half missed carry");
  pwm_rise_a: assert property (step[0] && g_ch[0].pwm && cnt_reg[0] == 8'hFF && cmp_reg[0] != 8'h00
    |=> pwm_lvl_reg[0] ##1 timer_output_pin_o[0] == (mode_reg[0][TMR_MODE_OE_BIT] && !g_ch[0].tog_pol))
    else $error("PWM level not raised on overflow");
  pin_low_a: assert property (!mode_reg[0][TMR_MODE_OE_BIT] |=> !timer_output_pin_o[0])
    else $error("disabled pin not low");
  sel_div1_a: assert property (sel_reg[0] == 3'h2 && mode_reg[0][TMR_MODE_RUN_BIT] |-> step[0])
    else $error("divide by one missed tick");
  pwm_fall_a: assert property (step[0] && g_ch[0].pwm && g_ch[0].cnt_plus == cmp_reg[0]
    |=> !pwm_lvl_reg[0])
    else $error("PWM level not dropped on match");
  pwm_free_a: assert property (step[0] && g_ch[0].pwm && g_ch[0].match8
    |=> cnt_reg[0] == $past(g_ch[0].cnt_plus))
    else $error("PWM counter cleared on match");
  casc_hold_a: assert property (casc && step[0] && cnt_reg[0] != 8'hFF && !match16
    |=> cnt_reg[1] == $past(cnt_reg[1]))
    else $error("upper half moved without carry");
  // the next four checks watch the upper channel, which the square-wave test drives
  // software set wins
  out_set_a: assert property (g_ch[1].wr_mode && pwdata_i[TMR_MODE_SET_BIT] && !pwdata_i[TMR_MODE_CLR_BIT]
    |=> outff_reg[1])
    else $error("output flip-flop not set");
  out_clear_a: assert property (g_ch[1].wr_mode && pwdata_i[TMR_MODE_CLR_BIT] && !pwdata_i[TMR_MODE_SET_BIT]
    |=> !outff_reg[1])
    else $error("output flip-flop not cleared");
  out_toggle_a: assert property (step[1] && !casc && !g_ch[1].pwm && g_ch[1].match8 && g_ch[1].tog_pol &&
    !g_ch[1].wr_mode |=> outff_reg[1] != $past(outff_reg[1]))
    else $error("output flip-flop missed toggle");
  upper_pin_low_a: assert property (!mode_reg[1][TMR_MODE_OE_BIT] |=> !timer_output_pin_o[1])
    else $error("disabled upper pin not low");
  ready_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("access not answered after one wait");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held past completion");
  map_err_a: assert property (psel_i && penable_i && !pready_o && !mapped |=> pslverr_o)
    else $error("unmapped access not flagged");

  cov_match_c: cover property (match_irq_o[0]);
  cov_casc_c: cover property (casc && match_irq_o[0]);
  cov_pwm_c: cover property (pwm_lvl_reg[1] ##1 !pwm_lvl_reg[1]);
  cov_err_c: cover property (pslverr_o);
  // square wave on the upper channel
  cov_toggle_c: cover property (g_ch[1].toggle);
endmodule : tmr_top

// >>> pkg/tmr_pkg.sv
package tmr_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the low nibble of the index)
  // ----------------------------------------------------------------
  localparam logic [31:0] TMR_CH0_COUNT_IDX = 32'hFFFFF5C0;
  localparam logic [31:0] TMR_CH1_COUNT_IDX = 32'hFFFFF5C1;
  localparam logic [31:0] TMR_CH0_MODE_IDX = 32'h0FFFF5C6;
  localparam logic [31:0] TMR_CH1_MODE_IDX = 32'h0FFFF5C7;
  localparam logic [31:0] TMR_CH0_CMP_IDX = 32'h0000_0008;
  localparam logic [31:0] TMR_CH1_CMP_IDX = 32'h0000_0009;
  localparam logic [31:0] TMR_CH0_CLKSEL_IDX = 32'h0000_000A;
  localparam logic [31:0] TMR_CH1_CLKSEL_IDX = 32'h0000_000B;
  // the decoder compares the low nibble of the index with paddr[5:2]
  localparam int TMR_IDX_BITS = 4;

  // ----------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------
  localparam int TMR_MODE_RUN_BIT = 7;
  localparam int TMR_MODE_PWM_BIT = 6;
  localparam int TMR_MODE_CASC_BIT = 4;
  localparam int TMR_MODE_SET_BIT = 3;
  localparam int TMR_MODE_CLR_BIT = 2;
  localparam int TMR_MODE_TOG_BIT = 1;
  localparam int TMR_MODE_OE_BIT = 0;

  // ----------------------------------------------------------------
  // reset values and the count maximum
  // ----------------------------------------------------------------
  localparam logic [7:0] TMR_MODE_RST = 8'h00;
  localparam logic [7:0] TMR_COUNT_RST = 8'h00;
  localparam logic [7:0] TMR_CMP_RST = 8'h00;
  localparam logic [2:0] TMR_CLKSEL_RST = 3'h0;
  localparam logic [7:0] TMR_COUNT_MAX = 8'hFF;

  // ----------------------------------------------------------------
  // count clock selection codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TMR_SEL_EV_FALL = 3'h0,
    TMR_SEL_EV_RISE = 3'h1,
    TMR_SEL_DIV1 = 3'h2,
    TMR_SEL_DIV2 = 3'h3,
    TMR_SEL_DIV4 = 3'h4,
    TMR_SEL_DIV64 = 3'h5,
    TMR_SEL_DIV256 = 3'h6,
    TMR_SEL_NEIGHBOUR = 3'h7
  } tmr_clksel_t;

  // prescaler taps: low bits all ones marks the divided tick
  localparam int TMR_TAP_DIV2 = 1;
  localparam int TMR_TAP_DIV4 = 2;
  localparam int TMR_TAP_DIV64 = 6;
  localparam int TMR_TAP_DIV256 = 8;
endpackage : tmr_pkg

// >>> test/tmr_event_source.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// external event source and load on the timer outputs
// ----------------------------------------------------------------
module tmr_event_source (
  input wire logic clk_i,
  input wire logic [1:0] timer_output_pin_i,
  output logic [1:0] event_input_pin_o,
  output logic neighbour_timer_irq_o
);
  // lines idle low, always driven, so no floating level reaches the pins
  initial begin
    event_input_pin_o = 2'h0;
    neighbour_timer_irq_o = 1'b0;
  end
  // sel 0/1 event pins, 2 neighbour irq; three clocks per level so the pin register sees it
  task automatic pulses(input int sel, input int k);
    for (int i = 0; i < 2 * k; i++) begin
      repeat (3) @(posedge clk_i);
      if (sel == 2) neighbour_timer_irq_o <= ~neighbour_timer_irq_o;
      else event_input_pin_o[sel] <= ~event_input_pin_o[sel];
    end
    repeat (4) @(posedge clk_i);
  endtask : pulses
  // load side: counts level changes seen on one timer output
  task automatic count_edges(input int ch, input int cyc, output int e);
    logic p;
    e = 0;
    p = timer_output_pin_i[ch];
    repeat (cyc) begin
      @(posedge clk_i);
      if (timer_output_pin_i[ch] !== p) e++;
      p = timer_output_pin_i[ch];
    end
  endtask : count_edges
endmodule : tmr_event_source

// >>> test/dual_8bit_event_timer_cascade_bench.sv
`timescale 1ns/1ps
module dual_8bit_event_timer_cascade_bench;
  import tmr_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk, rst, psel, penable, pwrite, pready, pslverr, nirq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0] ev, pin, irq;
  int n_mismatch, num_checks, n, g, v;
  int irq1_seen = 0;
  // word addresses: low nibble of each index, times four
  localparam logic [11:0] A_CNT0 = {6'h00, TMR_CH0_COUNT_IDX[3:0], 2'h0};
  localparam logic [11:0] A_MODE0 = {6'h00, TMR_CH0_MODE_IDX[3:0], 2'h0};
  localparam logic [11:0] A_CMP0 = {6'h00, TMR_CH0_CMP_IDX[3:0], 2'h0};
  localparam logic [11:0] A_CLK0 = {6'h00, TMR_CH0_CLKSEL_IDX[3:0], 2'h0};
  tmr_top dut (.clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .event_input_pin_i(ev), .neighbour_timer_irq_i(nirq), .timer_output_pin_o(pin), .match_irq_o(irq));
  tmr_event_source src (.clk_i(clk), .timer_output_pin_i(pin), .event_input_pin_o(ev),
    .neighbour_timer_irq_o(nirq));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // upper channel interrupt must stay quiet while cascaded
  always @(posedge clk) if (irq[1] === 1'b1) irq1_seen++;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one transfer; the master waits for pready, then checks that it came after exactly one wait state
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready wait", 32'h2, 32'(k));
  endtask : apb
  task automatic rd_chk(input string what, input int a, input logic [31:0] exp);
    apb(1'b0, 12'(a), 32'h0);
    chk(what, exp, rdat);
  endtask : rd_chk
  function automatic int div(input int code);
    case (code)
      3: return 2;
      4: return 4;
      5: return 64;
      6: return 256;
      default: return 1;
    endcase
  endfunction : div
  function automatic logic sig(input int s);
    return (s < 2) ? irq[s] : pin[s-2];
  endfunction : sig
  // cycles between two events: irq pulse for sel 0/1, pin change for sel 2/3
  task automatic gap(input int sel, output int cnt);
    logic p;
    for (int pass = 0; pass < 2; pass++) begin
      cnt = 0;
      p = sig(sel);
      do begin
        @(posedge clk);
        cnt++;
      end while (cnt < 3000 && !((sel < 2) ? sig(sel) === 1'b1 : sig(sel) !== p));
    end
  endtask : gap
  task automatic count_high(input int ch, output int h);
    h = 0;
    repeat (512) begin
      @(posedge clk);
      if (pin[ch] === 1'b1) h++;
    end
  endtask : count_high
  // stop, select clock and compare while halted, then run one interval
  task automatic run_interval(input int ch, input int code, input int cmp);
    apb(1'b1, 12'(A_MODE0 + 4 * ch), 32'h0);
    apb(1'b1, 12'(A_CLK0 + 4 * ch), 32'(code));
    apb(1'b1, 12'(A_CMP0 + 4 * ch), 32'(cmp));
    rd_chk("compare readback", A_CMP0 + 4 * ch, 32'(cmp));
    apb(1'b1, 12'(A_MODE0 + 4 * ch), 32'h80);
    gap(ch, g);
    chk("match interval", 32'((cmp + 1) * div(code)), 32'(g));
    apb(1'b1, 12'(A_MODE0 + 4 * ch), 32'h0);
    rd_chk("count after stop", A_CNT0 + 4 * ch, 32'h0);
  endtask : run_interval
  task automatic report_and_stop;
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------------------------------
  // watchdog: whole run is well under 90k cycles
  // ----------------------------------------------------------------
  initial begin
    #900000;
    n_mismatch++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; rst = 1'b1;
    n_mismatch = 0; num_checks = 0;
    void'($urandom(51190));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // every register clears on reset
    for (int i = 0; i < 12; i++) if (i < 2 || i > 5) rd_chk("reset value", 4 * i, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, A_CNT0, 32'h55);
    rd_chk("count read only", A_CNT0, 32'h0);
    // every divided clock, then the compare range ends
    for (int c = 2; c < 7; c++) run_interval(c % 2, c, (c < 5) ? $urandom_range(0, 40) : $urandom_range(0, 2));
    run_interval(0, 2, 0);
    run_interval(1, 2, 255);
    // square wave, output disable, set and clear on channel 1
    n = $urandom_range(3, 30);
    apb(1'b1, A_CMP0 + 12'h4, 32'(n));
    apb(1'b1, A_MODE0 + 12'h4, 32'h83);
    gap(3, g);
    chk("half period", 32'(n + 1), 32'(g));
    src.count_edges(1, 4 * (n + 1), g);
    chk("square edges", 32'h4, 32'(g));
    apb(1'b1, A_MODE0 + 12'h4, 32'h82);
    repeat (40) @(posedge clk);
    chk("pin disabled", 32'h0, {31'h0, pin[1]});
    apb(1'b1, A_MODE0 + 12'h4, 32'h09);
    repeat (3) @(posedge clk);
    chk("pin set", 32'h1, {31'h0, pin[1]});
    apb(1'b1, A_MODE0 + 12'h4, 32'h05);
    repeat (3) @(posedge clk);
    chk("pin clear", 32'h0, {31'h0, pin[1]});
    // free-running pwm on channel 0, both polarities
    n = $urandom_range(1, 254);
    apb(1'b1, A_CMP0, 32'(n));
    apb(1'b1, A_MODE0, 32'hC1);
    repeat (300) @(posedge clk);
    count_high(0, g);
    chk("pwm active width", 32'(2 * n), 32'(g));
    apb(1'b1, A_MODE0, 32'hC3);
    repeat (300) @(posedge clk);
    count_high(0, g);
    chk("pwm low active", 32'(512 - 2 * n), 32'(g));
    n = $urandom_range(1, 254);
    apb(1'b1, A_CMP0, 32'(n));
    repeat (300) @(posedge clk);
    count_high(0, g);
    chk("pwm rewritten width", 32'(512 - 2 * n), 32'(g));
    // event pin edges on channel 1, neighbour irq on channel 0
    for (int c = 0; c < 3; c++) begin
      v = (c == 2) ? 0 : 1;
      n = $urandom_range(1, 9);
      apb(1'b1, 12'(A_MODE0 + 4 * v), 32'h0);
      apb(1'b1, 12'(A_CLK0 + 4 * v), (c == 2) ? 32'h7 : 32'(c));
      apb(1'b1, 12'(A_CMP0 + 4 * v), 32'hFF);
      apb(1'b1, 12'(A_MODE0 + 4 * v), 32'h80);
      src.pulses((c == 2) ? 2 : 1, n);
      rd_chk("event count", A_CNT0 + 4 * v, 32'(n));
    end
    // cascade: 16-bit compare, lower irq only, lower stop clears all
    apb(1'b1, A_MODE0, 32'h0);
    apb(1'b1, A_MODE0 + 12'h4, 32'h10);
    v = 256 + $urandom_range(0, 255);
    apb(1'b1, A_CMP0, 32'(v % 256));
    apb(1'b1, A_CMP0 + 12'h4, 32'(v / 256));
    apb(1'b1, A_CLK0, 32'h2);
    n = irq1_seen;
    apb(1'b1, A_MODE0, 32'h80);
    gap(0, g);
    chk("cascade interval", 32'(v + 1), 32'(g));
    chk("upper irq quiet", 32'h0, 32'(irq1_seen - n));
    apb(1'b1, A_MODE0, 32'h0);
    for (int r = 0; r < 2; r++) begin
      rd_chk("cascade low", A_CNT0, 32'h0);
      rd_chk("cascade high", A_CNT0 + 4, 32'h0);
    end
    report_and_stop();
  end
endmodule : dual_8bit_event_timer_cascade_bench
